// *** hdl/scb_latch_bank.sv ***
`timescale 1ns/1ps
module scb_latch_bank (
	input  wire logic       mclk_i,
	input  wire logic       srst_i,
	input  wire logic       config_write_strobe_n_i,
	input  wire logic [2:0] cfg_addr_i,
	input  wire logic [6:0] cfg_data_i,
	input  wire logic       device_reset_n_i,
	input  wire logic       tx_input_clock_i,
	output logic            rx_clock_rate_o,
	output logic            training_clock_rate_o,
	output logic [1:0]      primary_detect_threshold_o,
	output logic [1:0]      secondary_detect_threshold_o,
	output logic            rx_enable_o,
	output logic [1:0]      rx_mode_select_o,
	output logic            rx_video_en_o,
	output logic            rx_selftest_en_o,
	output logic            rx_mode_invalid_o,
	output logic            reclk_out1_enable_o,
	output logic            reclk_out2_enable_o,
	output logic            reclk_logic_power_o,
	output logic            tx_clock_source_sel_o,
	output logic            tx_phase_bypass_o,
	output logic            tx_pll_rate_sel_o,
	output logic [4:0]      tx_pll_multiplier_o,
	output logic            tx_dual_edge_capture_o,
	output logic            tx_selftest_disable_o,
	output logic            tx_out1_enable_o,
	output logic            tx_out2_enable_o,
	output logic            tx_logic_power_o,
	output logic            phase_buffer_init_o
);

	typedef struct packed {
		logic [7:0][6:0] bank;
		logic            txclk_prev;
		logic            rx_clock_rate;
		logic            training_clock_rate;
		logic [1:0]      primary_thr;
		logic [1:0]      secondary_thr;
		logic            rx_enable;
		logic [1:0]      rx_mode;
		logic            rx_video;
		logic            rx_selftest;
		logic            rx_invalid;
		logic            reclk_oe1;
		logic            reclk_oe2;
		logic            reclk_power;
		logic            tx_clk_sel;
		logic            tx_bypass;
		logic            tx_rate;
		logic [4:0]      tx_mult;
		logic            tx_dual_edge;
		logic            tx_st_dis;
		logic            tx_oe1;
		logic            tx_oe2;
		logic            tx_power;
		logic            pab_pulse;
	} scb_state_t;

	scb_state_t  st_q;
	scb_state_t  st_d;

	logic [12:0] pin_raw;
	logic [12:0] pin_s;
	logic        strobe_n_s;
	logic [2:0]  addr_s;
	logic [6:0]  data_s;
	logic        dev_rst_n_s;
	logic        txclk_s;
	logic        wr_go;
	logic        wr_ok;
	logic        txclk_rise;
	logic        pab_pend;

	// every pin level crosses two flip-flops before use
	assign pin_raw = {config_write_strobe_n_i, device_reset_n_i, cfg_addr_i,
		cfg_data_i, tx_input_clock_i};

	scb_sync2 #(
		.W    (13),
		.INIT (scb_pkg::PIN_IDLE)
	) u_pin_sync (
		.mclk_i (mclk_i),
		.srst_i (srst_i),
		.pin_i  (pin_raw),
		.sync_o (pin_s)
	);

	// split the synchronised group back into its fields
	assign strobe_n_s  = pin_s[12];
	assign dev_rst_n_s = pin_s[11];
	assign addr_s      = pin_s[10:8];
	assign data_s      = pin_s[7:1];
	assign txclk_s     = pin_s[0];

	// a level-sensitive write: every cycle the strobe is low counts while the device reset is high
	assign wr_go = ~strobe_n_s & dev_rst_n_s;
	// test banks are not ours to store; writes there are dropped
	assign wr_ok = wr_go & (addr_s != scb_pkg::BANK_TEST_THREE)
		& (addr_s != scb_pkg::BANK_TEST_FOUR);

	// rising edge of the transmit input clock as seen on mclk
	assign txclk_rise = txclk_s & ~st_q.txclk_prev;
	assign pab_pend   = ~st_q.bank[scb_pkg::BANK_TX_DYNAMIC][
		scb_pkg::BIT_PAB_RESET];

	// next state: self clearing, bank update, reset, then field decode
	always_comb begin
		st_d            = st_q;
		st_d.txclk_prev = txclk_s;
		st_d.pab_pulse  = 1'b0;

		// pending re-centre is taken on a transmit clock edge
		if (txclk_rise && pab_pend) begin
			st_d.bank[scb_pkg::BANK_TX_DYNAMIC][scb_pkg::BIT_PAB_RESET] =
				1'b1;
			st_d.pab_pulse = 1'b1;
		end

		// a host write in the same cycle wins over the self clear
		if (wr_ok) begin
			st_d.bank[addr_s] = data_s;
		end

		// device reset pin or core reset reload the initial image
		if (srst_i || !dev_rst_n_s) begin
			st_d.bank       = scb_pkg::BANK_RST;
			st_d.txclk_prev = 1'b0;
			st_d.pab_pulse  = 1'b0;
		end

		// receive static and detector banks
		st_d.rx_clock_rate = st_d.bank[scb_pkg::BANK_RX_STATIC][
			scb_pkg::BIT_RX_CLOCK_RATE];
		st_d.training_clock_rate = st_d.bank[scb_pkg::BANK_RX_DETECT][
			scb_pkg::BIT_TRAIN_RATE];
		st_d.primary_thr = st_d.bank[scb_pkg::BANK_RX_DETECT][
			scb_pkg::BIT_PRI_THR_LO +: 2];
		st_d.secondary_thr = st_d.bank[scb_pkg::BANK_RX_DETECT][
			scb_pkg::BIT_SEC_THR_LO +: 2];

		// receive dynamic bank
		st_d.rx_enable = st_d.bank[scb_pkg::BANK_RX_DYNAMIC][
			scb_pkg::BIT_RX_ENABLE];
		st_d.rx_mode = {
			st_d.bank[scb_pkg::BANK_RX_DYNAMIC][scb_pkg::BIT_RX_MODE_HI],
			st_d.bank[scb_pkg::BANK_RX_DYNAMIC][scb_pkg::BIT_RX_MODE_LO]
		};
		st_d.rx_video    = (st_d.rx_mode == scb_pkg::RX_MODE_VIDEO);
		st_d.rx_selftest = (st_d.rx_mode == scb_pkg::RX_MODE_SELFTEST);
		st_d.rx_invalid  = ~st_d.rx_video & ~st_d.rx_selftest;

		// reclocker drivers, forced off while the device reset is low
		st_d.reclk_oe1 = st_d.bank[scb_pkg::BANK_RX_DYNAMIC][
			scb_pkg::BIT_RECLK_OE1] & dev_rst_n_s;
		st_d.reclk_oe2 = st_d.bank[scb_pkg::BANK_RX_DYNAMIC][
			scb_pkg::BIT_RECLK_OE2] & dev_rst_n_s;
		st_d.reclk_power = st_d.reclk_oe1 | st_d.reclk_oe2;

		// transmit clocking bank
		st_d.tx_clk_sel = st_d.bank[scb_pkg::BANK_TX_CLOCK][
			scb_pkg::BIT_TX_CLK_SEL];
		st_d.tx_bypass = st_d.tx_clk_sel;
		st_d.tx_rate = st_d.bank[scb_pkg::BANK_TX_CLOCK][
			scb_pkg::BIT_TX_RATE];
		st_d.tx_mult = st_d.tx_rate ? scb_pkg::TX_MULT_DOUBLE
			: scb_pkg::TX_MULT_BASE;
		st_d.tx_dual_edge = st_d.tx_clk_sel & st_d.tx_rate;

		// transmit dynamic bank
		st_d.tx_st_dis = st_d.bank[scb_pkg::BANK_TX_DYNAMIC][
			scb_pkg::BIT_TX_ST_DIS];
		st_d.tx_oe1 = st_d.bank[scb_pkg::BANK_TX_DYNAMIC][
			scb_pkg::BIT_TX_OE1] & dev_rst_n_s;
		st_d.tx_oe2 = st_d.bank[scb_pkg::BANK_TX_DYNAMIC][
			scb_pkg::BIT_TX_OE2] & dev_rst_n_s;
		st_d.tx_power = st_d.tx_oe1 | st_d.tx_oe2;
	end

	// the whole state advances on every clock
	always_ff @(posedge mclk_i) begin
		st_q <= st_d;
	end

	// outputs straight from the state flip-flops
	assign rx_clock_rate_o              = st_q.rx_clock_rate;
	assign training_clock_rate_o        = st_q.training_clock_rate;
	assign primary_detect_threshold_o   = st_q.primary_thr;
	assign secondary_detect_threshold_o = st_q.secondary_thr;
	assign rx_enable_o                  = st_q.rx_enable;
	assign rx_mode_select_o             = st_q.rx_mode;
	assign rx_video_en_o                = st_q.rx_video;
	assign rx_selftest_en_o             = st_q.rx_selftest;
	assign rx_mode_invalid_o            = st_q.rx_invalid;
	assign reclk_out1_enable_o          = st_q.reclk_oe1;
	assign reclk_out2_enable_o          = st_q.reclk_oe2;
	assign reclk_logic_power_o          = st_q.reclk_power;
	assign tx_clock_source_sel_o        = st_q.tx_clk_sel;
	assign tx_phase_bypass_o            = st_q.tx_bypass;
	assign tx_pll_rate_sel_o            = st_q.tx_rate;
	assign tx_pll_multiplier_o          = st_q.tx_mult;
	assign tx_dual_edge_capture_o       = st_q.tx_dual_edge;
	assign tx_selftest_disable_o        = st_q.tx_st_dis;
	assign tx_out1_enable_o             = st_q.tx_oe1;
	assign tx_out2_enable_o             = st_q.tx_oe2;
	assign tx_logic_power_o             = st_q.tx_power;
	assign phase_buffer_init_o          = st_q.pab_pulse;

	// checks on the latch behaviour
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (srst_i);

	// a taken write lands in its bank on the next edge
	sequence host_write_s;
		wr_ok && dev_rst_n_s;
	endsequence

	// a pending buffer re-centre meets a transmit clock edge
	sequence pab_take_s;
		pab_pend && txclk_rise && !wr_ok && dev_rst_n_s;
	endsequence

	// pending re-centre without a transmit clock edge
	sequence pab_hold_s;
		pab_pend && !txclk_rise && !wr_ok && dev_rst_n_s;
	endsequence

	bank_write_a: assert property (
		host_write_s |=> st_q.bank[$past(addr_s)] == $past(data_s))
		else $error("written bank does not hold the written value");

	test_bank_a: assert property (
		wr_go && !wr_ok |=> $stable(st_q.bank[scb_pkg::BANK_TX_DYNAMIC:
			scb_pkg::BANK_TX_CLOCK]))
		else $error("write to a test bank disturbed transmit banks");

	reset_image_a: assert property (
		!dev_rst_n_s |=> !rx_enable_o && rx_mode_select_o == 2'h3
			&& tx_clock_source_sel_o && !tx_pll_rate_sel_o
			&& tx_selftest_disable_o && !phase_buffer_init_o)
		else $error("device reset did not load initial values");

	drivers_off_a: assert property (
		!dev_rst_n_s |=> !reclk_out1_enable_o && !reclk_out2_enable_o
			&& !tx_out1_enable_o && !tx_out2_enable_o)
		else $error("serial driver enabled during device reset");

	mode_decode_a: assert property (
		rx_video_en_o |-> rx_mode_select_o == 2'h1 && !rx_mode_invalid_o)
		else $error("video reception with wrong mode code");

	reclk_power_a: assert property (
		!reclk_out1_enable_o && !reclk_out2_enable_o
			|-> !reclk_logic_power_o)
		else $error("reclocker powered with both drivers off");

	tx_power_a: assert property (
		tx_logic_power_o == (tx_out1_enable_o || tx_out2_enable_o))
		else $error("transmit power does not follow driver enables");

	tx_mult_a: assert property (
		tx_pll_multiplier_o == (tx_pll_rate_sel_o ? 5'h14 : 5'h0a))
		else $error("transmit multiplier does not match rate bit");

	dual_edge_a: assert property (
		tx_dual_edge_capture_o == (tx_clock_source_sel_o
			&& tx_pll_rate_sel_o))
		else $error("dual edge capture mismatch");

	pab_clear_a: assert property (
		pab_take_s |=> phase_buffer_init_o && !pab_pend
			##1 !phase_buffer_init_o)
		else $error("buffer reset did not pulse and clear itself");

	pab_wait_a: assert property (
		pab_hold_s |=> !phase_buffer_init_o && pab_pend)
		else $error("buffer reset acted without a transmit clock edge");

endmodule // scb_latch_bank

// *** hdl/scb_pkg.sv ***
// shared constants for the serial link configuration latch bank
package scb_pkg;

	// write port widths
	localparam int unsigned DATA_W = 7;
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned BANKS  = 8;

	// bank addresses
	localparam logic [2:0] BANK_RX_STATIC  = 3'h0;
	localparam logic [2:0] BANK_RX_DETECT  = 3'h1;
	localparam logic [2:0] BANK_RX_DYNAMIC = 3'h2;
	localparam logic [2:0] BANK_TEST_THREE = 3'h3;
	localparam logic [2:0] BANK_TEST_FOUR  = 3'h4;
	localparam logic [2:0] BANK_TX_STATIC  = 3'h5;
	localparam logic [2:0] BANK_TX_CLOCK   = 3'h6;
	localparam logic [2:0] BANK_TX_DYNAMIC = 3'h7;

	// values after reset, per bank kind
	localparam logic [6:0] RST_STATIC  = 7'h5f;
	localparam logic [6:0] RST_DETECT  = 7'h56;
	localparam logic [6:0] RST_DYNAMIC = 7'h59;
	localparam logic [6:0] RST_TEST    = 7'h00;

	// reset image of all eight banks, bank 7 in the top slot
	localparam logic [7:0][6:0] BANK_RST = {
		RST_DYNAMIC, RST_DETECT, RST_STATIC, RST_TEST,
		RST_TEST, RST_DYNAMIC, RST_DETECT, RST_STATIC};

	// field positions, receive banks
	localparam int unsigned BIT_RX_CLOCK_RATE = 0;
	localparam int unsigned BIT_TRAIN_RATE    = 0;
	localparam int unsigned BIT_PRI_THR_LO    = 3;
	localparam int unsigned BIT_SEC_THR_LO    = 5;
	localparam int unsigned BIT_RX_MODE_HI    = 6;
	localparam int unsigned BIT_RX_MODE_LO    = 4;
	localparam int unsigned BIT_RX_ENABLE     = 5;
	localparam int unsigned BIT_RECLK_OE2     = 2;
	localparam int unsigned BIT_RECLK_OE1     = 1;

	// field positions, transmit banks
	localparam int unsigned BIT_TX_RATE       = 0;
	localparam int unsigned BIT_TX_CLK_SEL    = 1;
	localparam int unsigned BIT_TX_ST_DIS     = 3;
	localparam int unsigned BIT_TX_OE2        = 2;
	localparam int unsigned BIT_TX_OE1        = 1;
	localparam int unsigned BIT_PAB_RESET     = 0;

	// receive mode codes
	localparam logic [1:0] RX_MODE_VIDEO    = 2'h1;
	localparam logic [1:0] RX_MODE_SELFTEST = 2'h2;
	localparam logic [1:0] RX_MODE_RESET    = 2'h3;

	// transmit pll multipliers
	localparam logic [4:0] TX_MULT_BASE   = 5'h0a;
	localparam logic [4:0] TX_MULT_DOUBLE = 5'h14;

	// idle level of the synchronised pins: strobe high, reset high
	localparam logic [12:0] PIN_IDLE = 13'h1801;

endpackage

// *** hdl/scb_sync2.sv ***
`timescale 1ns/1ps
// two flip-flop synchroniser for a group of pin levels
module scb_sync2 #(
	parameter int unsigned   W    = 1,
	parameter logic [W-1:0]  INIT = '0
) (
	input  wire logic         mclk_i,
	input  wire logic         srst_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} scb_sync_st_t;

	scb_sync_st_t st_q;
	scb_sync_st_t st_d;

	// first stage feeds only the second stage
	always_comb begin
		st_d        = st_q;
		st_d.meta   = pin_i;
		st_d.stable = st_q.meta;
		if (srst_i) begin
			st_d.meta   = INIT;
			st_d.stable = INIT;
		end
	end

	always_ff @(posedge mclk_i) begin
		st_q <= st_d;
	end

	assign sync_o = st_q.stable;

endmodule // scb_sync2

// *** testbench/scb_host_model.sv ***
`timescale 1ns/1ps
// host side of the configuration write pins
module scb_host_model #(
	parameter logic SPEED_SEL_HIGH = 1'b1
) (
	input  wire logic  mclk_i,
	output logic       config_write_strobe_n_o,
	output logic [2:0] cfg_addr_o,
	output logic [6:0] cfg_data_o
);
	// pins idle: strobe high, lines parked
	initial begin
		config_write_strobe_n_o = 1'b1;
		cfg_addr_o = 3'h0;
		cfg_data_o = 7'h00;
	end

	// one bank write; hold sets how many cycles the strobe stays low
	task automatic write_bank(input logic [2:0] addr, input logic [6:0] data,
		input int hold, output logic [6:0] sent);
		logic [6:0] d;
		d = data;
		case (addr)
		3'h0: d = (d & 7'h19) | 7'h40;
		3'h5: d = d & 7'h7d;
		3'h6: d = d & 7'h7b;
		3'h7: d = d & 7'h5f;
		default: d = d;
		endcase
		if (!SPEED_SEL_HIGH && addr == 3'h6) d[0] = 1'b0;
		sent = d;
		if (addr == 3'h3 || addr == 3'h4) return;
		@(posedge mclk_i);
		#1 cfg_addr_o = addr;
		cfg_data_o = d;
		repeat (2) @(posedge mclk_i);
		#1 config_write_strobe_n_o = 1'b0;
		repeat (hold) @(posedge mclk_i);
		#1 config_write_strobe_n_o = 1'b1;
		repeat (4) @(posedge mclk_i);
		// hold time over: lines show the inverse of the last value
		#1 cfg_addr_o = ~addr;
		cfg_data_o = ~d;
	endtask
endmodule // scb_host_model

// *** testbench/scb_latch_bank_tb.sv ***
`timescale 1ns/1ps
// self-checking bench for the configuration latch bank
module scb_latch_bank_tb;
	typedef struct {
		string       name;
		logic [31:0] exp;
	} scb_note_t;

	logic            mclk_i = 1'b0;
	logic            srst_i = 1'b1;
	logic            device_reset_n = 1'b1;
	logic            tx_input_clock = 1'b0;
	wire logic       strobe_n;
	wire logic [2:0] addr;
	wire logic [6:0] data;
	wire logic [27:0] outs;
	wire logic       pb_init;
	logic [3:0]      pulse_cnt = 4'h0;
	logic [3:0]      pulse_exp = 4'h0;
	logic            drv_on = 1'b1;
	logic [7:0][6:0] banks = scb_pkg::BANK_RST;
	logic [31:0]     lfsr_q = 32'hba92_1314;
	logic [6:0]      sent;
	int              n_errors = 0;
	int              num_checks = 0;
	scb_note_t       notes[$];
	event            result_ev;

	always #4 mclk_i = ~mclk_i;

	scb_host_model u_scb_host_model (
		.mclk_i                  (mclk_i),
		.config_write_strobe_n_o (strobe_n),
		.cfg_addr_o              (addr),
		.cfg_data_o              (data)
	);

	scb_latch_bank u_scb_latch_bank (
		.mclk_i                       (mclk_i),
		.srst_i                       (srst_i),
		.config_write_strobe_n_i      (strobe_n),
		.cfg_addr_i                   (addr),
		.cfg_data_i                   (data),
		.device_reset_n_i             (device_reset_n),
		.tx_input_clock_i             (tx_input_clock),
		.rx_clock_rate_o              (outs[0]),
		.training_clock_rate_o        (outs[1]),
		.primary_detect_threshold_o   (outs[3:2]),
		.secondary_detect_threshold_o (outs[5:4]),
		.rx_enable_o                  (outs[6]),
		.rx_mode_select_o             (outs[8:7]),
		.rx_video_en_o                (outs[9]),
		.rx_selftest_en_o             (outs[10]),
		.rx_mode_invalid_o            (outs[11]),
		.reclk_out1_enable_o          (outs[12]),
		.reclk_out2_enable_o          (outs[13]),
		.reclk_logic_power_o          (outs[14]),
		.tx_clock_source_sel_o        (outs[15]),
		.tx_phase_bypass_o            (outs[16]),
		.tx_pll_rate_sel_o            (outs[17]),
		.tx_pll_multiplier_o          (outs[22:18]),
		.tx_dual_edge_capture_o       (outs[23]),
		.tx_selftest_disable_o        (outs[24]),
		.tx_out1_enable_o             (outs[25]),
		.tx_out2_enable_o             (outs[26]),
		.tx_logic_power_o             (outs[27]),
		.phase_buffer_init_o          (pb_init)
	);

	// count re-centre pulses, each stands one cycle
	always @(posedge mclk_i)
		if (pb_init === 1'b1) pulse_cnt <= pulse_cnt + 4'h1;

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// expected port picture from the bank images
	function automatic logic [31:0] exp_vec(input logic [7:0][6:0] b,
		input logic on, input logic [3:0] pc);
		logic [1:0] m;
		logic       r1, r2, t1, t2, sel, rt;
		m = {b[2][6], b[2][4]};
		r1 = b[2][1] & on;
		r2 = b[2][2] & on;
		t1 = b[7][1] & on;
		t2 = b[7][2] & on;
		sel = b[6][1];
		rt = b[6][0];
		exp_vec = {pc, t1 | t2, t2, t1, b[7][3], sel & rt,
			rt ? scb_pkg::TX_MULT_DOUBLE : scb_pkg::TX_MULT_BASE, rt, sel, sel,
			r1 | r2, r2, r1, m == 2'h0 || m == 2'h3,
			m == scb_pkg::RX_MODE_SELFTEST, m == scb_pkg::RX_MODE_VIDEO, m,
			b[2][5], b[1][6:5], b[1][4:3], b[1][0], b[0][0]};
	endfunction

	task automatic note(input string name);
		notes.push_back('{name, exp_vec(banks, drv_on, pulse_exp)});
		-> result_ev;
	endtask

	// random hold length, then keep the image of what was sent
	task automatic wr(input logic [2:0] a, input logic [6:0] d);
		lfsr_q = lfsr_next(lfsr_q);
		u_scb_host_model.write_bank(a, d, 1 + int'(lfsr_q[8]), sent);
		banks[a] = sent;
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// compare the oldest note with the outputs when a result shows
	initial forever begin
		scb_note_t nt;
		@(result_ev);
		nt = notes.pop_front();
		num_checks++;
		if ({pulse_cnt, outs} !== nt.exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nt.name, nt.exp,
				{pulse_cnt, outs});
		end
	end

	// main sequence
	initial begin
		logic [6:0] d;
		repeat (4) @(posedge mclk_i);
		#1 srst_i = 1'b0;
		repeat (3) @(posedge mclk_i);
		#1 note("reset image");
		// random words into every writable bank, all four mode codes
		for (int i = 0; i < 24; i++) begin
			lfsr_q = lfsr_next(lfsr_q);
			d = lfsr_q[6:0];
			if (i % 6 == 2) {d[6], d[4]} = 2'(i / 6);
			if (i % 6 == 5) d[0] = 1'b1;
			wr((i % 6 < 3) ? 3'(i % 6) : 3'(i % 6 + 2), d);
			note("random write");
		end
		// re-centre waits for a transmit clock edge, then clears itself
		for (int j = 0; j < 2; j++) begin
			wr(3'h7, 7'h06);
			repeat (4) @(posedge mclk_i);
			#1 note("pending re-centre");
			repeat (2 - j) begin
				tx_input_clock = 1'b1;
				repeat (4) @(posedge mclk_i);
				#1 tx_input_clock = 1'b0;
				repeat (4) @(posedge mclk_i);
				#1;
			end
			pulse_exp = pulse_exp + 4'h1;
			note("re-centre pulse");
		end
		// device reset disables drivers and ignores writes
		wr(3'h2, 7'h36);
		wr(3'h7, 7'h07);
		note("drivers on");
		device_reset_n = 1'b0;
		drv_on = 1'b0;
		wr(3'h6, 7'h03);
		banks = scb_pkg::BANK_RST;
		note("device reset");
		device_reset_n = 1'b1;
		drv_on = 1'b1;
		repeat (3) @(posedge mclk_i);
		#1 note("after device reset");
		@(posedge mclk_i);
		wrap_up();
	end

	// watchdog: the run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge mclk_i);
		n_errors++;
		wrap_up();
	end
endmodule // scb_latch_bank_tb
